// >>> query_host.sv
// Host model issuing commands and word reads
`timescale 1ns/1ps
`default_nettype none
module query_host
  import query_pkg::*;
(
  input wire logic clk_in,
  output logic cmd_wr_out, rd_out,
  output var word_addr_t cmd_addr_out, rd_addr_out,
  output logic [7:0] cmd_data_out
);
  initial {cmd_wr_out, rd_out, cmd_addr_out, rd_addr_out, cmd_data_out} = 0;
  task automatic cmd(input int p, input logic [7:0] c);
    {cmd_wr_out, rd_out, cmd_data_out} = {2'b10, c};
    cmd_addr_out = {p[1:0], 16'h0000};
    @(negedge clk_in);
  endtask
  task automatic rd(input int p, input int o);
    {cmd_wr_out, rd_out, cmd_data_out} = {2'b01, ~cmd_data_out};
    rd_addr_out = {p[1:0], o[15:0]};
    @(negedge clk_in);
  endtask
  task automatic idle;
    {cmd_wr_out, rd_out, rd_addr_out} = {2'b00, ~rd_addr_out};
    @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// >>> query_pkg.sv
// Shared constants and types for the query table read-out block
package query_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int PART_W = 2;
  localparam int NUM_PARTS = 4;
  localparam int BLK_W = 6;
  localparam int NUM_BLKS = 64;
  localparam int BLK_SHIFT = 10;

  // ****************************************************************
  // Query space offsets (word addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_MFR_CODE = 16'h0000;
  localparam logic [ADDR_W-1:0] OFS_DEV_CODE = 16'h0001;
  localparam logic [ADDR_W-1:0] OFS_BLK_STATUS = 16'h0002;
  localparam logic [ADDR_W-1:0] OFS_VENDOR_LO = 16'h0004;
  localparam logic [ADDR_W-1:0] OFS_VENDOR_HI = 16'h000f;
  localparam logic [ADDR_W-1:0] OFS_IDENT = 16'h0010;
  localparam logic [ADDR_W-1:0] OFS_SYS_IF = 16'h001b;
  localparam logic [ADDR_W-1:0] OFS_GEOMETRY = 16'h0027;
  localparam logic [ADDR_W-1:0] OFS_TABLE_END = 16'h002c;

  // ****************************************************************
  // Field values
  // ****************************************************************
  localparam logic [7:0] CHAR_Q = 8'h51;
  localparam logic [7:0] CHAR_R = 8'h52;
  localparam logic [7:0] CHAR_Y = 8'h59;
  localparam logic [15:0] PRIMARY_CMD_SET = 16'h0003;
  localparam logic [15:0] EXT_TABLE_OFS = 16'h0039;
  localparam logic [15:0] ALT_CMD_SET = 16'h0000;
  localparam logic [15:0] ALT_TABLE_OFS = 16'h0000;
  // Device size exponent, plain default
  localparam logic [7:0] DEV_SIZE_CODE = 8'h17;
  // Arbitrary identity values
  localparam logic [7:0] MAKER_ID = 8'h5a;
  localparam logic [7:0] PART_ID = 8'ha5;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int LOCKED_BIT = 0;
  localparam int LOCKDOWN_BIT = 1;

  // ****************************************************************
  // Commands and modes
  // ****************************************************************
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;

  typedef enum logic [1:0] {
    MODE_ARRAY,
    MODE_QUERY,
    MODE_STATUS
  } read_mode_t;

  typedef struct packed {
    logic [PART_W-1:0] part;
    logic [ADDR_W-1:0] offset;
  } word_addr_t;

  typedef struct packed {
    logic [7:0] high_data_lane;
    logic [7:0] low_data_lane;
  } data_word_t;

endpackage

// >>> query_readout.sv
// Query read-out logic with per-partition read mode and block status
//
// Functional notes
// - Query bytes appear on the low data lane and the high lane reads zero.
// - Query offsets are word addresses and the table starts at word 10h.
// - Words 10h, 11h and 12h return 51h, 52h and 59h.
// - Multi-byte fields are little-endian across rising offsets.
// - The query command switches the addressed partition to query output.
// - Offsets 4 to Fh are vendor space with no standard content.
// - Ident group at 10h, system interface at 1Bh, layout at 27h.
// - Words 15h and 16h hold the extended table pointer.
// - Block base plus two returns the block status, bit 0 locked.
// - Bit 1 of the block status shows lock-down.
// - Bits 2 to 7 of the block status read zero.
// - Each partition keeps its read mode until a recognised command is written to it.
// - After reset every partition returns array data.
`timescale 1ns/1ps
`default_nettype none
module query_readout (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // Command write
  input wire logic CMD_WR_IN,
  input wire query_pkg::word_addr_t CMD_ADDR_IN,
  input wire logic [7:0] CMD_DATA_IN,
  // Read request
  input wire logic RD_IN,
  input wire query_pkg::word_addr_t RD_ADDR_IN,
  input wire query_pkg::data_word_t ARRAY_DATA_IN,
  input wire logic [7:0] STATUS_DATA_IN,
  // Block lock state
  input wire logic [query_pkg::NUM_BLKS-1:0] BLK_LOCKED_IN,
  input wire logic [query_pkg::NUM_BLKS-1:0] BLK_LOCKDOWN_IN,
  // Read answer
  output var query_pkg::data_word_t RD_DATA_OUT,
  output logic RD_VALID_OUT
);
  import query_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Map a command code onto the output kind it selects
  function automatic read_mode_t decode_cmd(input logic [7:0] cmd,
                                            input read_mode_t cur);
    case (cmd)
      CMD_READ_ARRAY: decode_cmd = MODE_ARRAY;
      CMD_READ_QUERY: decode_cmd = MODE_QUERY;
      CMD_READ_ID: decode_cmd = MODE_QUERY;
      CMD_READ_STATUS: decode_cmd = MODE_STATUS;
      default: decode_cmd = cur;
    endcase
  endfunction

  // Block index held in the upper offset bits
  function automatic logic [BLK_W-1:0] block_of(
    input logic [ADDR_W-1:0] ofs
  );
    block_of = ofs[BLK_SHIFT +: BLK_W];
  endfunction

  // Word position inside the block, widened to a table offset
  function automatic logic [ADDR_W-1:0] table_ofs_of(
    input logic [ADDR_W-1:0] ofs
  );
    table_ofs_of = {{BLK_W{1'b0}}, ofs[BLK_SHIFT-1:0]};
  endfunction

  // Byte on the low lane, zero on the high lane
  function automatic data_word_t low_lane_word(input logic [7:0] val);
    low_lane_word.high_data_lane = ZERO_BYTE;
    low_lane_word.low_data_lane = val;
  endfunction

  // ****************************************************************
  // Partition read modes
  // ****************************************************************
  read_mode_t mode_ff [NUM_PARTS];

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PARTS; gp++) begin : g_part
      logic cmd_hit;
      read_mode_t nxt_mode;

      // Only a write aimed at this partition moves its mode
      assign cmd_hit = CMD_WR_IN && (CMD_ADDR_IN.part == PART_W'(gp));

      always_comb begin
        nxt_mode = mode_ff[gp];
        if (cmd_hit) begin
          nxt_mode = decode_cmd(CMD_DATA_IN, mode_ff[gp]);
        end
      end

      always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
          mode_ff[gp] <= MODE_ARRAY;
        end else begin
          mode_ff[gp] <= nxt_mode;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Block lock state
  // ****************************************************************
  logic [1:0] lock_pair [NUM_BLKS];

  genvar gb;
  generate
    for (gb = 0; gb < NUM_BLKS; gb++) begin : g_blk
      assign lock_pair[gb] = {BLK_LOCKDOWN_IN[gb], BLK_LOCKED_IN[gb]};
    end
  endgenerate

  // ****************************************************************
  // Query lookup
  // ****************************************************************
  logic [BLK_W-1:0] blk_idx;
  logic [ADDR_W-1:0] rel_ofs;
  logic [1:0] blk_state;
  logic [7:0] query_byte;

  // Every block repeats the table, so base plus two is its status word
  assign blk_idx = block_of(RD_ADDR_IN.offset);
  assign rel_ofs = table_ofs_of(RD_ADDR_IN.offset);
  assign blk_state = lock_pair[blk_idx];

  query_rom u_rom (
    .offset_in(rel_ofs),
    .blk_state_in(blk_state),
    .byte_out(query_byte)
  );

  // ****************************************************************
  // Read answer
  // ****************************************************************
  read_mode_t rd_mode;
  data_word_t nxt_rd_data;

  // A command in the same cycle as a read only affects later reads
  assign rd_mode = mode_ff[RD_ADDR_IN.part];

  always_comb begin
    case (rd_mode)
      MODE_QUERY: nxt_rd_data = low_lane_word(query_byte);
      MODE_STATUS: nxt_rd_data = low_lane_word(STATUS_DATA_IN);
      MODE_ARRAY: nxt_rd_data = ARRAY_DATA_IN;
      default: nxt_rd_data = ARRAY_DATA_IN;
    endcase
  end

  // Data holds between reads
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      RD_DATA_OUT <= '0;
    end else if (RD_IN) begin
      RD_DATA_OUT <= nxt_rd_data;
    end
  end

  // One-cycle answer strobe
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      RD_VALID_OUT <= 1'b0;
    end else begin
      RD_VALID_OUT <= RD_IN;
    end
  end
endmodule
`default_nettype wire

// >>> query_readout_asserts.sv
// Port checker for the query read-out block
`timescale 1ns/1ps
`default_nettype none
module query_readout_asserts
  import query_pkg::*;
(
  input wire logic CLK_IN, RST_N_IN, CMD_WR_IN, RD_IN, RD_VALID_OUT,
  input wire word_addr_t CMD_ADDR_IN, RD_ADDR_IN,
  input wire logic [7:0] CMD_DATA_IN,
  input wire data_word_t ARRAY_DATA_IN, RD_DATA_OUT,
  input wire logic [NUM_BLKS-1:0] BLK_LOCKED_IN, BLK_LOCKDOWN_IN
);
  read_mode_t m_ff [NUM_PARTS];
  logic rq, ra;
  logic [9:0] o;
  logic [5:0] b;
  logic [7:0] bs;
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < NUM_PARTS; i++) m_ff[i] <= MODE_ARRAY;
    end else if (CMD_WR_IN) begin
      case (CMD_DATA_IN)
        CMD_READ_ARRAY: m_ff[CMD_ADDR_IN.part] <= MODE_ARRAY;
        CMD_READ_QUERY, CMD_READ_ID: m_ff[CMD_ADDR_IN.part] <= MODE_QUERY;
        CMD_READ_STATUS: m_ff[CMD_ADDR_IN.part] <= MODE_STATUS;
        default: ;
      endcase
    end
  end
  assign rq = RD_IN && m_ff[RD_ADDR_IN.part] == MODE_QUERY;
  assign ra = RD_IN && m_ff[RD_ADDR_IN.part] == MODE_ARRAY;
  assign o = RD_ADDR_IN.offset[9:0];
  assign b = RD_ADDR_IN.offset[15:10];
  assign bs = {6'h00, BLK_LOCKDOWN_IN[b], BLK_LOCKED_IN[b]};
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_valid; RD_IN |=> RD_VALID_OUT; endproperty
  a_valid: assert property (p_valid) else $error("no valid");
  property p_hold; !RD_IN |=> !RD_VALID_OUT && $stable(RD_DATA_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved");
  property p_hi; rq |=> RD_DATA_OUT.high_data_lane == ZERO_BYTE; endproperty
  a_hi: assert property (p_hi) else $error("high lane set");
  property p_qry; rq && o inside {[10'h010:10'h012]} |=>
    RD_DATA_OUT == ($past(o) == 10'h010 ? 16'h0051 :
    $past(o) == 10'h011 ? 16'h0052 : 16'h0059); endproperty
  a_qry: assert property (p_qry) else $error("bad ident");
  property p_ptr; rq && o == 10'h015 |=> RD_DATA_OUT == 16'h0039 ##1 1;
  endproperty
  a_ptr: assert property (p_ptr) else $error("bad pointer");
  property p_vend; rq && o inside {[10'h004:10'h00f]} |=> RD_DATA_OUT == 0;
  endproperty
  a_vend: assert property (p_vend) else $error("vendor data");
  property p_bsr; rq && o == 10'h002 |=> RD_DATA_OUT == {8'h00, $past(bs)};
  endproperty
  a_bsr: assert property (p_bsr) else $error("bad lock");
  property p_arr; ra |=> RD_DATA_OUT == $past(ARRAY_DATA_IN); endproperty
  a_arr: assert property (p_arr) else $error("bad array");
endmodule
bind query_readout query_readout_asserts query_readout_asserts_i (
  .CLK_IN, .RST_N_IN, .CMD_WR_IN, .RD_IN, .RD_VALID_OUT, .CMD_ADDR_IN,
  .RD_ADDR_IN, .CMD_DATA_IN, .ARRAY_DATA_IN, .RD_DATA_OUT,
  .BLK_LOCKED_IN, .BLK_LOCKDOWN_IN);
`default_nettype wire

// >>> query_readout_test.sv
// Self-checking bench for the query read-out block
`timescale 1ns/1ps
`default_nettype none
module query_readout_test;
  import query_pkg::*;
  logic clk, rst_n, cmd_wr, rd, valid;
  word_addr_t cmd_addr, rd_addr;
  logic [7:0] cmd_data, st;
  data_word_t ad, rdata;
  logic [NUM_BLKS-1:0] lk, lkd;
  int mismatches, cmp_count, seed = 32'h4349;
  int mode [NUM_PARTS];
  int tbl [28] = '{'h51, 'h52, 'h59, 'h03, 0, 'h39, 0, 0, 0, 0, 0,
    'h17, 'h19, 'hb4, 'hc6, 'h04, 0, 'h0a, 0, 'h04, 0, 'h03, 0,
    DEV_SIZE_CODE, 'h01, 0, 0, 0};
  logic [7:0] codes [5] = '{8'hff, 8'h98, 8'h90, 8'h70, 8'h11};
  query_readout query_readout_i (.CLK_IN(clk), .RST_N_IN(rst_n),
    .CMD_WR_IN(cmd_wr), .CMD_ADDR_IN(cmd_addr), .CMD_DATA_IN(cmd_data),
    .RD_IN(rd), .RD_ADDR_IN(rd_addr), .ARRAY_DATA_IN(ad),
    .STATUS_DATA_IN(st), .BLK_LOCKED_IN(lk), .BLK_LOCKDOWN_IN(lkd),
    .RD_DATA_OUT(rdata), .RD_VALID_OUT(valid));
  query_host query_host_i (.clk_in(clk), .cmd_wr_out(cmd_wr), .rd_out(rd),
    .cmd_addr_out(cmd_addr), .rd_addr_out(rd_addr),
    .cmd_data_out(cmd_data));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cm(input int p, input logic [7:0] c);
    query_host_i.cmd(p, c);
    if (c == 8'hff) mode[p] = 0;
    else if (c == 8'h98 || c == 8'h90) mode[p] = 1;
    else if (c == 8'h70) mode[p] = 2;
  endtask
  task automatic rq(input int p, input int o);
    int q, b, e;
    q = o & 'h3ff;
    b = (o >> 10) & 63;
    ad = 16'($random(seed));
    st = 8'($random(seed));
    if (mode[p] == 0) e = ad;
    else if (mode[p] == 2) e = st;
    else if (q == 2) e = {lkd[b], lk[b]};
    else if (q < 2) e = q ? PART_ID : MAKER_ID;
    else if (q < 'h10) e = 0;
    else if (q < 'h2c) e = tbl[q - 'h10];
    else e = 0;
    query_host_i.rd(p, o);
    chk(16'(valid), 16'h0001);
    chk(rdata, e[15:0]);
  endtask
  initial begin
    {rst_n, ad, st, lk, lkd} = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    for (int p = 0; p < NUM_PARTS; p++) rq(p, $random(seed));
    $display("Test reset done");
    cm(1, CMD_READ_QUERY);
    for (int i = 0; i < 'h30; i++) rq(1, i);
    rq(0, 'h10);
    $display("Test sweep done");
    for (int i = 0; i < 400; i++) begin
      lk = {$random(seed), $random(seed)};
      lkd = {$random(seed), $random(seed)};
      if ({$random(seed)} % 3 == 0) cm({$random(seed)} % 4, codes[i % 5]);
      else rq({$random(seed)} % 4, ({$random(seed)} % 64 << 10) + i % 'h30);
    end
    query_host_i.idle();
    $display("Test random done");
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    $display("Error at %0t: timeout", $time);
    finish_test();
  end
endmodule
`default_nettype wire

// >>> query_rom.sv
// Combinational query table lookup by word offset
`timescale 1ns/1ps
`default_nettype none
module query_rom (
  // Lookup
  input wire logic [15:0] offset_in,
  input wire logic [1:0] blk_state_in,
  output logic [7:0] byte_out
);
  import query_pkg::*;

  always_comb begin
    byte_out = ZERO_BYTE;
    case (offset_in)
      OFS_MFR_CODE: byte_out = MAKER_ID;
      OFS_DEV_CODE: byte_out = PART_ID;
      OFS_BLK_STATUS: begin
        byte_out[LOCKED_BIT] = blk_state_in[LOCKED_BIT];
        byte_out[LOCKDOWN_BIT] = blk_state_in[LOCKDOWN_BIT];
      end
      OFS_IDENT: byte_out = CHAR_Q;
      OFS_IDENT + 16'h0001: byte_out = CHAR_R;
      OFS_IDENT + 16'h0002: byte_out = CHAR_Y;
      OFS_IDENT + 16'h0003: byte_out = PRIMARY_CMD_SET[7:0];
      OFS_IDENT + 16'h0004: byte_out = PRIMARY_CMD_SET[15:8];
      OFS_IDENT + 16'h0005: byte_out = EXT_TABLE_OFS[7:0];
      OFS_IDENT + 16'h0006: byte_out = EXT_TABLE_OFS[15:8];
      OFS_IDENT + 16'h0007: byte_out = ALT_CMD_SET[7:0];
      OFS_IDENT + 16'h0008: byte_out = ALT_CMD_SET[15:8];
      OFS_IDENT + 16'h0009: byte_out = ALT_TABLE_OFS[7:0];
      OFS_IDENT + 16'h000a: byte_out = ALT_TABLE_OFS[15:8];
      OFS_SYS_IF: byte_out = 8'h17;
      OFS_SYS_IF + 16'h0001: byte_out = 8'h19;
      OFS_SYS_IF + 16'h0002: byte_out = 8'hb4;
      OFS_SYS_IF + 16'h0003: byte_out = 8'hc6;
      OFS_SYS_IF + 16'h0004: byte_out = 8'h04;
      OFS_SYS_IF + 16'h0006: byte_out = 8'h0a;
      OFS_SYS_IF + 16'h0008: byte_out = 8'h04;
      OFS_SYS_IF + 16'h000a: byte_out = 8'h03;
      OFS_GEOMETRY: byte_out = DEV_SIZE_CODE;
      OFS_GEOMETRY + 16'h0001: byte_out = 8'h01;
      default: byte_out = ZERO_BYTE;
    endcase
  end
endmodule
`default_nettype wire
